// *** core/usd_pkg.sv ***
// Purpose: constants and types for the serial port status and driver-enable block
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes: register offsets are local choices; data sits in the low 8 bits
//
// Overview of operation
// - drive enable asserts one to two bit periods before the start bit
// - drive enable releases one clock after the last stop bit
// - back-to-back characters keep drive enable asserted between them
// - polarity bit: 0 drive enable active high, 1 active low
// - separate tx and rx interrupts; baud timer interrupts when receiver disabled
// - holding-empty sets and interrupts after the first bit shifts out
// - writing transmit data clears holding-empty
// - parity error flag set on bad parity, cleared by data read
// - overrun set on unread data; read clears only when no byte waiting
// - framing error set on missing stop bit, cleared by data read
// - break flag set on all-zero frame, cleared by data read
// - all-done bit is 1 only when shifter empty and character finished
// - clear-to-send status bit reads the live input level
// - filter 01 address only, 10 match plus data, 11 matched data only
// - control bit enables the nine-bit frame format
// - in nine-bit mode the ninth bit carries the programmed value
`default_nettype none

package usd_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_STAT0 = 4'h1;
    localparam logic [3:0] ADDR_CTL0 = 4'h2;
    localparam logic [3:0] ADDR_CTL1 = 4'h3;
    localparam logic [3:0] ADDR_BRGH = 4'h4;
    localparam logic [3:0] ADDR_BRGL = 4'h5;
    localparam logic [3:0] ADDR_ADRCMP = 4'h6;
    localparam logic [3:0] ADDR_IRQST = 4'h7;
    localparam logic [3:0] ADDR_IRQMSK = 4'h8;
    localparam logic [15:0] BRG_RST = 16'h006c;
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam int unsigned IRQ_TX = 0;
    localparam int unsigned IRQ_RX = 1;
    localparam int unsigned IRQ_BRG = 2;
    localparam int unsigned IRQ_W = 3;
    localparam logic [1:0] FLT_ALL = 2'h0;
    localparam logic [1:0] FLT_ADDR = 2'h1;
    localparam logic [1:0] FLT_MATCH = 2'h2;
    localparam logic [1:0] FLT_DATA = 2'h3;
    localparam logic [3:0] OVS = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;

    // ctl0: [7] tx_en [6] rx_en [5] parity_en [4] parity_odd [3] two_stop [2] brg_timer
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic brg_timer;
        logic [1:0] spare;
    } usd_ctl0_s;

    // ctl1: [7:6] filter [5] nine_bit_mode_on [4] ninth_bit_value [3] drive_active_level
    typedef struct packed {
        logic [1:0] filter;
        logic nine_bit_mode_on;
        logic ninth_bit_value;
        logic drive_active_level;
        logic [2:0] spare;
    } usd_ctl1_s;

    typedef struct packed {
        logic rx_byte_waiting;
        logic parity_error_flag;
        logic overrun_flag;
        logic framing_error_flag;
        logic break_seen_flag;
        logic tx_holding_empty;
        logic tx_all_done;
        logic cts_level;
    } usd_stat_s;

    typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_HOLD}
        usd_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} usd_rx_e;
endpackage

`default_nettype wire

// *** core/usd_uart.sv ***
// Purpose: serial transmitter/receiver with driver enable, status flags and interrupts
// Assumes: rx and cts are synchronous to clock; one bit period = 16 ticks of baud divider
// Notes: read data appear the cycle after the read strobe

`default_nettype none

module usd_uart (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // serial line
    input wire logic rx,
    input wire logic cts_n,
    output logic tx,
    output logic transceiver_drive_enable,
    // interrupt
    output logic irq
);
    // ==========================================================
    // registers
    usd_pkg::usd_ctl0_s ctl0_r;
    usd_pkg::usd_ctl1_s ctl1_r;
    logic [15:0] brg_r;
    logic [7:0] adrcmp_r;
    logic [usd_pkg::IRQ_W-1:0] irq_st_r, irq_msk_r;
    logic [7:0] rdata_r;
    logic [7:0] thr_r;
    logic hold_empty_r;
    logic [7:0] rbr_r;
    logic rdw_r, pe_r, oe_r, fe_r, brk_r;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a, input logic s);
        hit = s && (a == ref_a);
    endfunction

    wire logic data_wr = hit(addr, usd_pkg::ADDR_DATA, wr_stb);
    wire logic data_rd = hit(addr, usd_pkg::ADDR_DATA, rd_stb);

    // ==========================================================
    // baud tick: one tick per 1/16 bit
    logic [15:0] brg_cnt_r;
    wire logic tick = (brg_cnt_r == 16'h0000);
    always_ff @(posedge clock) begin
        if (reset) begin
            brg_cnt_r <= usd_pkg::BRG_RST;
        end else if (tick) begin
            brg_cnt_r <= brg_r;
        end else begin
            brg_cnt_r <= brg_cnt_r - 16'h0001;
        end
    end

    // ==========================================================
    // transmitter
    usd_pkg::usd_tx_e tx_st_r;
    logic [3:0] tx_sub_r;
    logic [3:0] tx_bit_r;
    logic [7:0] tsr_r;
    logic tx_par_r;
    logic tx_ninth_r;
    logic tx_r;
    logic tx_first_r;
    wire logic bit_end = tick && (tx_sub_r == usd_pkg::OVS);
    wire logic tx_pend = !hold_empty_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_st_r <= usd_pkg::TX_IDLE;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tsr_r <= 8'h00;
            tx_par_r <= 1'b0;
            tx_ninth_r <= 1'b0;
            tx_r <= 1'b1;
            tx_first_r <= 1'b0;
        end else begin
            tx_first_r <= 1'b0;
            if (tick) begin
                tx_sub_r <= tx_sub_r + 4'h1;
            end
            unique case (tx_st_r)
                usd_pkg::TX_IDLE: begin
                    tx_r <= 1'b1;
                    // leave only on a tick, so the lead is a whole bit however slow the divider
                    if (tx_pend && ctl0_r.tx_en && tick) begin
                        tx_st_r <= usd_pkg::TX_LEAD;
                        tx_sub_r <= 4'h0;
                    end
                end
                usd_pkg::TX_LEAD: begin
                    // sixteen ticks from a tick-aligned entry: exactly one bit of lead
                    if (bit_end) begin
                        tx_st_r <= usd_pkg::TX_START;
                        tsr_r <= thr_r;
                        tx_par_r <= ctl0_r.parity_odd;
                        tx_ninth_r <= ctl1_r.ninth_bit_value;
                        tx_r <= 1'b0;
                    end
                end
                usd_pkg::TX_START: begin
                    if (bit_end) begin
                        tx_st_r <= usd_pkg::TX_DATA;
                        tx_bit_r <= 4'h0;
                        tx_r <= tsr_r[0];
                        tx_par_r <= tx_par_r ^ tsr_r[0];
                    end
                end
                usd_pkg::TX_DATA: begin
                    if (bit_end) begin
                        if (tx_bit_r == 4'h0) begin
                            tx_first_r <= 1'b1;
                        end
                        if (tx_bit_r == 4'h7) begin
                            if (ctl1_r.nine_bit_mode_on) begin
                                tx_st_r <= usd_pkg::TX_NINTH;
                                tx_r <= tx_ninth_r;
                            end else if (ctl0_r.parity_en) begin
                                tx_st_r <= usd_pkg::TX_NINTH;
                                tx_r <= tx_par_r;
                            end else begin
                                tx_st_r <= usd_pkg::TX_STOP;
                                tx_r <= 1'b1;
                            end
                            tx_bit_r <= 4'h0;
                        end else begin
                            tsr_r <= {1'b0, tsr_r[7:1]};
                            tx_r <= tsr_r[1];
                            tx_par_r <= tx_par_r ^ tsr_r[1];
                            tx_bit_r <= tx_bit_r + 4'h1;
                        end
                    end
                end
                usd_pkg::TX_NINTH: begin
                    if (bit_end) begin
                        tx_st_r <= usd_pkg::TX_STOP;
                        tx_r <= 1'b1;
                        tx_bit_r <= 4'h0;
                    end
                end
                usd_pkg::TX_STOP: begin
                    if (bit_end) begin
                        if (ctl0_r.two_stop && tx_bit_r == 4'h0) begin
                            tx_bit_r <= 4'h1;
                        end else begin
                            tx_st_r <= usd_pkg::TX_HOLD;
                        end
                    end
                end
                usd_pkg::TX_HOLD: begin
                    // one clock after the last stop bit; a pending byte skips the release
                    if (tx_pend && ctl0_r.tx_en) begin
                        tx_st_r <= usd_pkg::TX_START;
                        tsr_r <= thr_r;
                        tx_par_r <= ctl0_r.parity_odd;
                        tx_ninth_r <= ctl1_r.ninth_bit_value;
                        tx_r <= 1'b0;
                        tx_sub_r <= tick ? 4'h1 : 4'h0;
                    end else begin
                        tx_st_r <= usd_pkg::TX_IDLE;
                    end
                end
                default: tx_st_r <= usd_pkg::TX_IDLE;
            endcase
        end
    end

    wire logic de_act = (tx_st_r != usd_pkg::TX_IDLE);
    assign tx = tx_r;
    assign transceiver_drive_enable = de_act ^ ctl1_r.drive_active_level;
    wire logic tx_all_done = (tx_st_r == usd_pkg::TX_IDLE) && hold_empty_r;

    // holding register: loaded by write, freed after first data bit leaves
    always_ff @(posedge clock) begin
        if (reset) begin
            thr_r <= 8'h00;
            hold_empty_r <= 1'b1;
        end else if (data_wr) begin
            thr_r <= wdata;
            hold_empty_r <= 1'b0;
        end else if (tx_first_r) begin
            hold_empty_r <= 1'b1;
        end
    end

    // ==========================================================
    // receiver
    usd_pkg::usd_rx_e rx_st_r;
    logic [3:0] rx_sub_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rsr_r;
    logic rx_par_r;
    logic rx_ninth_r;
    logic rx_any_one_r;
    logic rx_done_r;
    logic rx_pe_ev_r, rx_fe_ev_r, rx_brk_ev_r;
    logic addr_match_r;
    logic rx_prev_r;
    wire logic rx_mid = tick && (rx_sub_r == usd_pkg::OVS_MID);

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_st_r <= usd_pkg::RX_IDLE;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rsr_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_ninth_r <= 1'b0;
            rx_any_one_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_pe_ev_r <= 1'b0;
            rx_fe_ev_r <= 1'b0;
            rx_brk_ev_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else begin
            rx_done_r <= 1'b0;
            rx_prev_r <= rx;
            if (tick) begin
                rx_sub_r <= rx_sub_r + 4'h1;
            end
            unique case (rx_st_r)
                usd_pkg::RX_IDLE: begin
                    // a falling edge starts a frame; a line left low after a break does not
                    if (rx_prev_r && !rx && ctl0_r.rx_en) begin
                        rx_st_r <= usd_pkg::RX_START;
                        rx_sub_r <= 4'h0;
                    end
                end
                usd_pkg::RX_START: begin
                    if (rx_mid) begin
                        rx_st_r <= rx ? usd_pkg::RX_IDLE : usd_pkg::RX_DATA;
                        rx_bit_r <= 4'h0;
                        rx_par_r <= ctl0_r.parity_odd;
                        rx_any_one_r <= 1'b0;
                    end
                end
                usd_pkg::RX_DATA: begin
                    if (rx_mid) begin
                        rsr_r <= {rx, rsr_r[7:1]};
                        rx_par_r <= rx_par_r ^ rx;
                        rx_any_one_r <= rx_any_one_r | rx;
                        if (rx_bit_r == 4'h7) begin
                            rx_st_r <= (ctl1_r.nine_bit_mode_on || ctl0_r.parity_en) ?
                                usd_pkg::RX_NINTH : usd_pkg::RX_STOP;
                        end
                        rx_bit_r <= rx_bit_r + 4'h1;
                    end
                end
                usd_pkg::RX_NINTH: begin
                    if (rx_mid) begin
                        rx_ninth_r <= rx;
                        rx_any_one_r <= rx_any_one_r | rx;
                        rx_st_r <= usd_pkg::RX_STOP;
                    end
                end
                usd_pkg::RX_STOP: begin
                    if (rx_mid) begin
                        rx_st_r <= usd_pkg::RX_IDLE;
                        rx_done_r <= 1'b1;
                        rx_pe_ev_r <= ctl0_r.parity_en && !ctl1_r.nine_bit_mode_on &&
                            (rx_par_r != rx_ninth_r);
                        rx_fe_ev_r <= !rx;
                        rx_brk_ev_r <= !rx && !rx_any_one_r;
                        if (!ctl1_r.nine_bit_mode_on) begin
                            rx_ninth_r <= 1'b0;
                        end
                    end
                end
                default: rx_st_r <= usd_pkg::RX_IDLE;
            endcase
        end
    end

    // multiprocessor filter: ninth bit high marks an address byte
    wire logic is_addr = ctl1_r.nine_bit_mode_on && rx_ninth_r;
    wire logic match = (rsr_r == adrcmp_r);
    logic rx_accept;
    always_comb begin
        unique case (ctl1_r.filter)
            usd_pkg::FLT_ALL: rx_accept = 1'b1;
            usd_pkg::FLT_ADDR: rx_accept = is_addr;
            usd_pkg::FLT_MATCH: rx_accept = is_addr ? match : addr_match_r;
            usd_pkg::FLT_DATA: rx_accept = !is_addr && addr_match_r;
        endcase
        if (!ctl1_r.nine_bit_mode_on) begin
            rx_accept = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            addr_match_r <= 1'b0;
        end else if (rx_done_r && is_addr) begin
            addr_match_r <= match;
        end
    end

    wire logic rx_load = rx_done_r && rx_accept;
    // flags: a new event wins over the clearing read
    always_ff @(posedge clock) begin
        if (reset) begin
            rbr_r <= 8'h00;
            rdw_r <= 1'b0;
            pe_r <= 1'b0;
            oe_r <= 1'b0;
            fe_r <= 1'b0;
            brk_r <= 1'b0;
        end else begin
            if (rx_load) begin
                rbr_r <= rsr_r;
            end
            rdw_r <= rx_load | (rdw_r & !data_rd);
            pe_r <= (rx_load & rx_pe_ev_r) | (pe_r & !data_rd);
            fe_r <= (rx_load & rx_fe_ev_r) | (fe_r & !data_rd);
            brk_r <= (rx_load & rx_brk_ev_r) | (brk_r & !data_rd);
            oe_r <= (rx_load & rdw_r & !data_rd) | (oe_r & !(data_rd & !rdw_r));
        end
    end

    // ==========================================================
    // interrupts: sticky, write-one-to-clear, masked onto irq
    logic [usd_pkg::IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[usd_pkg::IRQ_TX] = tx_first_r;
        ev[usd_pkg::IRQ_RX] = rx_load;
        ev[usd_pkg::IRQ_BRG] = tick && ctl0_r.brg_timer && !ctl0_r.rx_en;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= ev | (irq_st_r &
                ~(hit(addr, usd_pkg::ADDR_IRQST, wr_stb) ? wdata[usd_pkg::IRQ_W-1:0] : '0));
        end
    end
    assign irq = |(irq_st_r & irq_msk_r);

    // ==========================================================
    // register writes
    always_ff @(posedge clock) begin
        if (reset) begin
            ctl0_r <= usd_pkg::CTL0_RST;
            ctl1_r <= usd_pkg::CTL1_RST;
            brg_r <= usd_pkg::BRG_RST;
            adrcmp_r <= 8'h00;
            irq_msk_r <= '0;
        end else if (wr_stb) begin
            unique case (addr)
                usd_pkg::ADDR_CTL0: ctl0_r <= wdata;
                usd_pkg::ADDR_CTL1: ctl1_r <= wdata;
                usd_pkg::ADDR_BRGH: brg_r[15:8] <= wdata;
                usd_pkg::ADDR_BRGL: brg_r[7:0] <= wdata;
                usd_pkg::ADDR_ADRCMP: adrcmp_r <= wdata;
                usd_pkg::ADDR_IRQMSK: irq_msk_r <= wdata[usd_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // register reads, one cycle later; unmapped reads as zero
    usd_pkg::usd_stat_s stat;
    always_comb begin
        stat.rx_byte_waiting = rdw_r;
        stat.parity_error_flag = pe_r;
        stat.overrun_flag = oe_r;
        stat.framing_error_flag = fe_r;
        stat.break_seen_flag = brk_r;
        stat.tx_holding_empty = hold_empty_r;
        stat.tx_all_done = tx_all_done;
        stat.cts_level = cts_n;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                usd_pkg::ADDR_DATA: rdata_r <= rbr_r;
                usd_pkg::ADDR_STAT0: rdata_r <= stat;
                usd_pkg::ADDR_CTL0: rdata_r <= ctl0_r;
                usd_pkg::ADDR_CTL1: rdata_r <= ctl1_r;
                usd_pkg::ADDR_BRGH: rdata_r <= brg_r[15:8];
                usd_pkg::ADDR_BRGL: rdata_r <= brg_r[7:0];
                usd_pkg::ADDR_ADRCMP: rdata_r <= adrcmp_r;
                usd_pkg::ADDR_IRQST: rdata_r <= {5'h00, irq_st_r};
                usd_pkg::ADDR_IRQMSK: rdata_r <= {5'h00, irq_msk_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata = rdata_r;

    // ==========================================================
    // checks
    a_de_release: assert property (@(posedge clock) disable iff (reset)
        (tx_st_r == usd_pkg::TX_STOP) ##1 (tx_st_r == usd_pkg::TX_HOLD) && hold_empty_r
        |=> !de_act) else $error("drive enable not released after stop");
    a_de_polarity: assert property (@(posedge clock) disable iff (reset)
        transceiver_drive_enable == (de_act ^ ctl1_r.drive_active_level))
        else $error("drive enable polarity wrong");
    a_de_before_start: assert property (@(posedge clock) disable iff (reset)
        $fell(tx_r) && $past(tx_st_r) == usd_pkg::TX_LEAD |-> $past(de_act, 16))
        else $error("drive enable lead too short");
    a_de_back_to_back: assert property (@(posedge clock) disable iff (reset)
        (tx_st_r == usd_pkg::TX_HOLD) && !hold_empty_r && ctl0_r.tx_en |=> de_act)
        else $error("drive enable dropped between characters");
    a_hold_clear_wr: assert property (@(posedge clock) disable iff (reset)
        data_wr |=> !hold_empty_r) else $error("holding flag not cleared by write");
    a_tx_irq_first: assert property (@(posedge clock) disable iff (reset)
        tx_first_r |=> hold_empty_r && irq_st_r[usd_pkg::IRQ_TX])
        else $error("tx interrupt missing after first bit");
    a_pe_clear: assert property (@(posedge clock) disable iff (reset)
        data_rd && !rx_load |=> !pe_r && !fe_r && !brk_r)
        else $error("error flags not cleared by read");
    a_oe_hold: assert property (@(posedge clock) disable iff (reset)
        oe_r && data_rd && rdw_r |=> oe_r) else $error("overrun cleared while byte waiting");
    a_all_done: assert property (@(posedge clock) disable iff (reset)
        !tx_r |-> !tx_all_done) else $error("all-done while sending");
    a_filter_addr: assert property (@(posedge clock) disable iff (reset)
        rx_load && ctl1_r.nine_bit_mode_on && ctl1_r.filter == usd_pkg::FLT_ADDR |-> is_addr)
        else $error("data byte passed address-only filter");
    c_back_to_back: cover property (@(posedge clock) disable iff (reset)
        (tx_st_r == usd_pkg::TX_HOLD) ##1 (tx_st_r == usd_pkg::TX_START));
    c_rx_overrun: cover property (@(posedge clock) disable iff (reset) $rose(oe_r));
    c_rx_break: cover property (@(posedge clock) disable iff (reset) $rose(brk_r));
    c_nine_bit: cover property (@(posedge clock) disable iff (reset)
        rx_load && is_addr && match);
endmodule

`default_nettype wire

// *** verification/usd_far_node.sv ***
// Purpose: far serial node that talks to the block over rx and tx
// Assumes: bit period given in clocks; line idles high
// Notes: sampling is mid-bit, lsb first
`default_nettype none
module usd_far_node #(parameter int BIT = 32) (
    // clock
    input wire logic clock,
    // serial line
    input wire logic tx,
    output logic rx
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int start_at = 0;
    initial rx = 1'b1;
    always @(posedge clock) cyc <= cyc + 1;
    // ==========
    // frame send, bits[0] is the start bit
    task automatic send(input logic [10:0] bits, input int n);
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            rx <= bits[i];
            repeat (BIT) @(posedge clock);
        end
        rx <= 1'b1;
        repeat (BIT) @(posedge clock);
    endtask
    // ==========
    // frame capture, returns in the middle of the bit after the eighth data bit
    task automatic grab(output logic [7:0] b);
        @(posedge clock iff tx === 1'b0);
        start_at = cyc;
        repeat (BIT + BIT / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx;
            repeat (BIT) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: register-level tests of the serial status and driver-enable block
// Assumes: baud divider 1, so one bit is 32 clocks
// Notes: far node model drives rx and decodes tx
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 32;
    localparam logic [3:0] ST = usd_pkg::ADDR_STAT0;
    localparam logic [3:0] DT = usd_pkg::ADDR_DATA;
    logic clock = 0, reset = 1, wr_stb = 0, rd_stb = 0, cts_n = 1;
    logic [3:0] addr = '0;
    logic [7:0] wdata = '0, rdata, s, b;
    logic rx, tx, de, irq;
    int num_errors = 0, cmp_count = 0, td;
    logic [10:0] fr[4] = '{11'h4b4, 11'h6b4, 11'h0b4, 11'h000};
    logic [7:0] fl[4] = '{8'h80, 8'hc0, 8'h90, 8'h98};
    usd_uart dut_u (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .rx(rx), .cts_n(cts_n), .tx(tx),
        .transceiver_drive_enable(de), .irq(irq));
    usd_far_node #(.BIT(BIT)) far_u (.clock(clock), .tx(tx), .rx(rx));
    initial forever #2.5 clock = ~clock;
    // ==========
    // bus tasks
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        rd(ST, s);
        chk("status", s & m, e);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        st(8'hff, 8'h07);
        @(posedge clock) cts_n <= 1'b0;
        st(8'h01, 8'h00);
        $display("test reset and cts done");
        wr(usd_pkg::ADDR_BRGL, 8'h01);
        wr(usd_pkg::ADDR_IRQMSK, 8'h03);
        wr(usd_pkg::ADDR_CTL0, 8'h80);
        fork
            begin
                far_u.grab(b);
                chk("tx byte", b, 8'ha6);
                far_u.grab(b);
                chk("tx byte", b, 8'h3c);
            end
            begin
                wr(DT, 8'ha6);
                @(posedge clock iff de === 1'b1);
                td = far_u.cyc;
                @(posedge clock iff tx === 1'b0);
                chk("de lead", 8'(far_u.cyc - td >= BIT && far_u.cyc - td <= 2 * BIT), 8'h01);
                st(8'h06, 8'h00);
                repeat (2 * BIT) @(posedge clock);
                st(8'h06, 8'h04);
                rd(usd_pkg::ADDR_IRQST, s);
                chk("tx irq", s, 8'h01);
                wr(DT, 8'h3c);
                wr(usd_pkg::ADDR_IRQST, 8'h01);
                @(posedge clock) #1 chk("irq", {7'h0, irq}, 8'h00);
                @(posedge clock iff de === 1'b0);
                // a back-to-back start bit is one clock short; the release clock makes it up
                chk("de release", 8'(far_u.cyc - far_u.start_at - 10 * BIT), 8'h00);
                st(8'h06, 8'h06);
            end
        join
        wr(usd_pkg::ADDR_CTL1, 8'h08);
        @(posedge clock) #1 chk("de idle", {7'h0, de}, 8'h01);
        wr(usd_pkg::ADDR_CTL1, 8'h30);
        wr(DT, 8'h81);
        far_u.grab(b);
        chk("ninth bit", {7'h0, tx}, 8'h01);
        chk("nine-bit byte", b, 8'h81);
        wr(usd_pkg::ADDR_CTL1, 8'h00);
        wr(usd_pkg::ADDR_IRQST, 8'h07);
        $display("test transmit done");
        wr(usd_pkg::ADDR_CTL0, 8'he0);
        for (int k = 0; k < 4; k++) begin
            far_u.send(fr[k], 11);
            st(8'hf8, fl[k]);
            chk("rx irq", {7'h0, irq}, 8'h01);
            wr(usd_pkg::ADDR_IRQST, 8'h02);
            rd(DT, s);
            chk("rx data", s, k == 3 ? 8'h00 : 8'h5a);
            st(8'hf8, 8'h00);
        end
        far_u.send(fr[0], 11);
        far_u.send(fr[0], 11);
        st(8'hf8, 8'ha0);
        rd(DT, s);
        st(8'hf8, 8'h20);
        rd(DT, s);
        st(8'hf8, 8'h00);
        $display("test receive flags done");
        wr(usd_pkg::ADDR_CTL0, 8'h40);
        wr(usd_pkg::ADDR_CTL1, 8'h60);
        far_u.send(11'h466, 11);
        st(8'h80, 8'h00);
        far_u.send(11'h666, 11);
        st(8'h80, 8'h80);
        rd(DT, s);
        chk("address byte", s, 8'h33);
        $display("test address filter done");
        wr(usd_pkg::ADDR_ADRCMP, 8'h33);
        wr(usd_pkg::ADDR_CTL1, 8'he0);
        far_u.send(11'h466, 11);
        far_u.send(11'h666, 11);
        st(8'h80, 8'h00);
        far_u.send(11'h4b4, 11);
        rd(DT, s);
        chk("matched data", s, 8'h5a);
        wr(usd_pkg::ADDR_CTL0, 8'h04);
        repeat (4) @(posedge clock);
        rd(usd_pkg::ADDR_IRQST, s);
        chk("timer irq", s & 8'h04, 8'h04);
        $display("test matched data and timer done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
